// File: rtl/txd_pkg.sv
// Shared constants and types for the transmit front-end link and datapath.
// Assumes both link ends and the datapath run on one 250 MHz system clock.
package txd_pkg;
	// Lane configurations
	localparam logic [1:0] LM_CMOS1 = 2'h0; // One single-ended lane, I/Q interleaved
	localparam logic [1:0] LM_CMOS4 = 2'h1; // Four single-ended lanes, bytes
	localparam logic [1:0] LM_LVDS2 = 2'h2; // Separate I and Q lanes
	localparam logic [1:0] LM_LVDS1 = 2'h3; // One differential lane, interleaved
	// Symbol width codes
	localparam logic [1:0] WC_2     = 2'h0;
	localparam logic [1:0] WC_8     = 2'h1;
	localparam logic [1:0] WC_12    = 2'h2;
	localparam logic [1:0] WC_16    = 2'h3;
	// Tap filter modes
	localparam logic [2:0] FIR_OFF  = 3'h0; // Bypass
	localparam logic [2:0] FIR_PAR  = 3'h1; // I and Q filters in parallel
	localparam logic [2:0] FIR_ION  = 3'h2; // In-phase filter only
	localparam logic [2:0] FIR_QON  = 3'h3; // Quadrature filter only
	localparam logic [2:0] FIR_SEQ  = 3'h4; // I filter then Q filter in series
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_RATE = 8'h04;
	localparam logic [7:0] REG_COEF = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	// Control field positions
	localparam int CTL_LANE = 0;  // [1:0]
	localparam int CTL_WID  = 2;  // [3:2]
	localparam int CTL_FIR  = 4;  // [6:4]
	localparam int CTL_MOD  = 7;  // Frequency modulator enable
	localparam int CTL_UPC  = 8;  // Upconverter enable
	localparam int CTL_DFM  = 9;  // Direct synthesizer modulation
	localparam int CTL_L1   = 10; // [11:10] log2 stage-1 ratio
	localparam int CTL_L2   = 12; // [13:12] log2 stage-2 ratio
	localparam int CTL_LEN  = 14; // Link enable
	localparam int CTL_OCK  = 15; // Output clock on in LVDS modes
	localparam int CTL_CLR  = 31; // Write 1: synchronous datapath clear
	localparam int RT_LINK  = 8;  // [23:8] link half period in cycles
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] RATE_RST = 32'h0000_0400; // Half period 4, DAC every cycle
	localparam int TAPS   = 128; // Tap count
	localparam int COEF_W = 24;  // Coefficient width

	// Gray-coded filter sequencer states
	typedef enum logic [1:0] {
		F_IDLE = 2'h0,
		F_MAC  = 2'h1,
		F_OUT  = 2'h3,
		F_CLR  = 2'h2
	} txd_fir_st_type;

	// Symbol width actually used for a lane mode and width code
	function automatic logic [4:0] txd_eff_width(input logic [1:0] lane,
		input logic [1:0] code);
		logic [4:0] w;
		w = 5'h10;
		if (lane == LM_CMOS1 && code == WC_2) begin
			w = 5'h02;
		end else if (lane == LM_CMOS1 && code == WC_8) begin
			w = 5'h08;
		end else if (lane[1] && code == WC_12) begin
			w = 5'h0C;
		end
		return w;
	endfunction
endpackage

// File: rtl/txd_link_if.sv
// Serial link between the baseband end and the transmit front end.
// Assumes a testbench joins the two modports; all signals are plain wires.
interface txd_link_if;
	logic       clk_out; // Link clock made by the front end
	logic       clk_in;  // Link clock returned by the baseband
	logic       strobe;  // High on the first bit of each symbol
	logic [3:0] data;    // Data lanes 0..3

	modport dev (
		output clk_out,
		input  clk_in,
		input  strobe,
		input  data
	);
	modport bb (
		input  clk_out,
		output clk_in,
		output strobe,
		output data
	);
endinterface

// File: rtl/txd_baseband.sv
// Baseband end: serialises I/Q pairs onto the link.
// Assumes the front end supplies clk_out; all link timing follows it.
module txd_baseband (
	input  wire logic        clk_sys,    // System clock
	input  wire logic        rstn,       // Async reset, active low
	txd_link_if.bb           link,       // Serial link
	input  wire logic [1:0]  lane_mode,  // Lane configuration
	input  wire logic [1:0]  width_code, // Symbol width code
	input  wire logic [15:0] tx_i,       // I sample, left-justified
	input  wire logic [15:0] tx_q,       // Q sample, left-justified
	input  wire logic        tx_valid,   // Sample pair offered
	output logic             tx_ready,   // Pair taken this cycle
	output logic             busy        // Frame on the wire
);
	logic [1:0]  co_sync_ff; // Two-stage sync of clk_out
	logic        co_prev_ff; // Previous synced level
	logic        act_ff;     // Sending a frame
	logic [4:0]  b_ff;       // Bit index inside the frame
	logic [15:0] i_ff;       // I being sent
	logic [15:0] q_ff;       // Q being sent
	logic        ck_ff;      // Returned clock
	logic        stb_ff;     // Strobe
	logic [3:0]  dat_ff;     // Lane data
	logic [4:0]  w;          // Effective width
	logic [4:0]  last;       // Last bit index
	logic        fall;       // clk_out falling edge

	// Lane bits and strobe for bit index b
	function automatic logic [4:0] lanes_of(input logic [15:0] i, input logic [15:0] q,
		input logic [4:0] b, input logic [1:0] lm, input logic [4:0] wd);
		logic [4:0] r;
		logic [3:0] p;
		r = 5'h00;
		p = b[3:0];
		if (lm == txd_pkg::LM_CMOS4) begin
			// Bytes: I high, I low, Q high, Q low
			r = {b == 5'h00, q[4'(4'h7 - p)], q[4'(4'hF - p)],
				i[4'(4'h7 - p)], i[4'(4'hF - p)]};
		end else if (lm == txd_pkg::LM_LVDS2) begin
			r = {b == 5'h00, 2'h0, q[4'(4'hF - p)], i[4'(4'hF - p)]};
		end else if (b < wd) begin
			r = {b == 5'h00, 3'h0, i[4'(4'hF - p)]};
		end else begin
			r = {b == wd, 3'h0, q[4'(5'h0F - (b - wd))]};
		end
		return r;
	endfunction

	always_comb begin
		w = txd_pkg::txd_eff_width(lane_mode, width_code);
		if (lane_mode == txd_pkg::LM_CMOS4) begin
			last = 5'h07;
		end else if (lane_mode == txd_pkg::LM_LVDS2) begin
			last = 5'(w - 5'h01);
		end else begin
			last = 5'((w << 1) - 5'h01);
		end
	end

	assign fall = co_prev_ff & ~co_sync_ff[1];
	assign tx_ready = fall & tx_valid & (~act_ff | (b_ff == last));
	assign busy = act_ff;
	assign link.clk_in = ck_ff;
	assign link.strobe = stb_ff;
	assign link.data = dat_ff;

	// Sample the device clock; everything is timed from it
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			co_sync_ff <= 2'h0;
			co_prev_ff <= 1'b0;
			ck_ff <= 1'b0;
		end else begin
			co_sync_ff <= {co_sync_ff[0], link.clk_out};
			co_prev_ff <= co_sync_ff[1];
			ck_ff <= co_sync_ff[1];
		end
	end

	// Change data on the falling edge so the far end samples mid-bit
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			act_ff <= 1'b0;
			b_ff <= 5'h00;
			i_ff <= 16'h0000;
			q_ff <= 16'h0000;
			stb_ff <= 1'b0;
			dat_ff <= 4'h0;
		end else if (tx_ready) begin
			// New pair, back to back if one is waiting
			act_ff <= 1'b1;
			b_ff <= 5'h00;
			i_ff <= tx_i;
			q_ff <= tx_q;
			{stb_ff, dat_ff} <= lanes_of(tx_i, tx_q, 5'h00, lane_mode, w);
		end else if (fall && act_ff && b_ff != last) begin
			b_ff <= b_ff + 5'h01;
			{stb_ff, dat_ff} <= lanes_of(i_ff, q_ff, 5'(b_ff + 5'h01), lane_mode, w);
		end else if (fall && act_ff) begin
			// Frame done with nothing waiting: park the lanes
			act_ff <= 1'b0;
			stb_ff <= 1'b0;
			dat_ff <= 4'h0;
		end
	end
endmodule

// File: rtl/txd_device.sv
// Transmit front end: link deframer, tap filters, interpolators, modulators.
// Assumes the baseband derives its link signals from clk_out.
module txd_device #(
	parameter int TAPS = txd_pkg::TAPS,  // Filter length
	parameter int CW   = txd_pkg::COEF_W // Coefficient width
) (
	input  wire logic        clk_sys,   // System clock
	input  wire logic        rstn,      // Async reset, active low
	txd_link_if.dev          link,      // Serial link
	input  wire logic [7:0]  reg_addr,  // Register byte address
	input  wire logic [31:0] reg_wdata, // Write data
	input  wire logic        reg_wr,    // Write strobe
	input  wire logic        reg_rd,    // Read strobe
	output logic      [31:0] reg_rdata, // Read data, cycle after strobe
	output logic      [15:0] dac_i,     // DAC I sample
	output logic      [15:0] dac_q,     // DAC Q sample
	output logic             dac_valid, // DAC sample strobe
	output logic      [15:0] sdm_word,  // Synthesizer modulation word
	output logic             sdm_valid, // Word strobe
	output logic             dac_pd,    // DAC may power down
	output logic             lpf_pd     // Analog filter may power down
);
	localparam int AW = $clog2(TAPS);
	localparam int PW = 16 + CW;     // Product width
	localparam int AC = PW + AW;     // Accumulator width
	// Local names for the sequencer states
	localparam txd_pkg::txd_fir_st_type F_IDLE = txd_pkg::F_IDLE;
	localparam txd_pkg::txd_fir_st_type F_MAC  = txd_pkg::F_MAC;
	localparam txd_pkg::txd_fir_st_type F_OUT  = txd_pkg::F_OUT;
	localparam txd_pkg::txd_fir_st_type F_CLR  = txd_pkg::F_CLR;

	logic        [31:0] ctl_ff, rate_ff, rd_ff; // Registers, read data
	logic        [15:0] lk_cnt_ff;   // Link clock divider
	logic               lk_clk_ff;   // Link clock out
	logic         [5:0] sy1_ff, sy2_ff; // Two-stage input sync
	logic               ck_prev_ff;  // Previous synced clock
	logic         [4:0] pos_ff;      // Bit position in symbol
	logic               ph_q_ff;     // Next interleaved symbol is Q
	logic               sym_on_ff;   // Current symbol was opened by a strobe
	logic        [15:0] sh_ff [4];   // Lane shift registers
	logic        [15:0] hold_i_ff;   // Interleaved I awaiting Q
	logic signed [15:0] df_i_ff, df_q_ff; // Deframed pair
	logic               df_vld_ff;   // Pair strobe
	logic        [15:0] sym_cnt_ff;  // Pairs received
	logic               ovr_ff;      // Pair dropped while filter busy
	txd_pkg::txd_fir_st_type fs_ff;  // Filter sequencer
	logic      [AW-1:0] k_ff, wp_ff; // Tap index, write pointer
	logic               pass_ff;     // Second pass in series mode
	logic signed [AC-1:0] acc_i_ff, acc_q_ff;
	logic signed [15:0] in_i_ff, in_q_ff;   // Pass-through copy
	logic signed [15:0] fir_i_ff, fir_q_ff; // Latest filter output
	logic signed [15:0] dl_i [TAPS];  // Delay lines
	logic signed [15:0] dl_q [TAPS];
	logic signed [CW-1:0] cf_i [TAPS]; // Coefficients
	logic signed [CW-1:0] cf_q [TAPS];
	logic         [7:0] dac_cnt_ff;  // DAC rate divider
	logic         [2:0] k1_ff, k2_ff; // Interpolation phases
	logic signed [15:0] o1_i_ff, o1_q_ff, n1_i_ff, n1_q_ff; // Stage 1 ends
	logic signed [15:0] o2_i_ff, o2_q_ff, n2_i_ff, n2_q_ff; // Stage 2 ends
	logic        [15:0] nco_ff;      // Modulator phase
	logic         [1:0] rot_ff;      // Upconverter quarter turn
	logic         [4:0] w;
	logic         [1:0] lane;
	logic         [2:0] fm;
	logic               rise, last, clr, tick, wrap1, wrap2, dfm, take;
	logic        [15:0] sh_n [4];
	logic signed [15:0] s1_i, s1_q, p_i, p_q;
	logic      [AW-1:0] rp;

	// Saturate accumulator (coefficients scaled by 2^(CW-1)) to 16 bits
	function automatic logic signed [15:0] sat(input logic signed [AC-1:0] a);
		logic signed [AC-1:0] s;
		s = a >>> (CW - 1);
		if (s > AC'(32767)) return 16'sh7FFF;
		if (s < -AC'(32768)) return 16'sh8000;
		return s[15:0];
	endfunction

	// Linear interpolation between o and n at phase k of 2^l
	function automatic logic signed [15:0] lin(input logic signed [15:0] o,
		input logic signed [15:0] n, input logic [2:0] k, input logic [1:0] l);
		logic signed [20:0] d;
		d = ((21'(n) - 21'(o)) * $signed({18'h0, k})) >>> l;
		return 16'(21'(o) + d);
	endfunction

	// Eight-point sine for the frequency modulator
	function automatic logic signed [15:0] sin8(input logic [2:0] p);
		logic signed [15:0] t [8];
		t = '{16'sh0000, 16'sh5A82, 16'sh7FFF, 16'sh5A82,
			16'sh0000, 16'shA57E, 16'sh8001, 16'shA57E};
		return t[p];
	endfunction

	always_comb begin
		lane = ctl_ff[txd_pkg::CTL_LANE +: 2];
		fm = ctl_ff[txd_pkg::CTL_FIR +: 3];
		dfm = ctl_ff[txd_pkg::CTL_DFM];
		w = txd_pkg::txd_eff_width(lane, ctl_ff[txd_pkg::CTL_WID +: 2]);
		rise = sy2_ff[5] & ~ck_prev_ff & ctl_ff[txd_pkg::CTL_LEN];
		clr = reg_wr & (reg_addr == txd_pkg::REG_CTRL) & reg_wdata[txd_pkg::CTL_CLR];
		for (int l = 0; l < 4; l++) begin
			sh_n[l] = {sh_ff[l][14:0], sy2_ff[l]};
		end
		if (sy2_ff[4]) begin
			sh_n[0] = {15'h0000, sy2_ff[0]};
			sh_n[1] = {15'h0000, sy2_ff[1]};
			sh_n[2] = {15'h0000, sy2_ff[2]};
			sh_n[3] = {15'h0000, sy2_ff[3]};
		end
		// Strobe restarts the symbol at bit zero
		last = (lane == txd_pkg::LM_CMOS4) ? ((sy2_ff[4] ? 5'h00 : pos_ff) == 5'h07)
			: ((sy2_ff[4] ? 5'h00 : pos_ff) == 5'(w - 5'h01));
		// Only strobed symbols count; idle clocking would upset the I/Q order
		take = rise & last & (sy2_ff[4] | sym_on_ff);
		rp = AW'(wp_ff - k_ff);
	end

	// Registers; writes steer the datapath, status shows its progress
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ctl_ff <= txd_pkg::CTRL_RST;
			rate_ff <= txd_pkg::RATE_RST;
			rd_ff <= 32'h0000_0000;
		end else begin
			if (reg_wr && reg_addr == txd_pkg::REG_CTRL) begin
				ctl_ff <= {1'b0, reg_wdata[30:0]};
			end
			if (reg_wr && reg_addr == txd_pkg::REG_RATE) begin
				rate_ff <= {8'h00, reg_wdata[23:0]};
			end
			if (reg_rd) begin
				unique case (reg_addr)
					txd_pkg::REG_CTRL: rd_ff <= ctl_ff;
					txd_pkg::REG_RATE: rd_ff <= rate_ff;
					txd_pkg::REG_STAT: rd_ff <= {sym_cnt_ff, 14'h0000, fs_ff != F_IDLE, ovr_ff};
					default:           rd_ff <= 32'h0000_0000; // Unmapped reads zero
				endcase
			end
		end
	end
	assign reg_rdata = rd_ff;

	// Coefficient load: index [30:24], Q filter select [31]
	always_ff @(posedge clk_sys) begin
		if (reg_wr && reg_addr == txd_pkg::REG_COEF && reg_wdata[31]) begin
			cf_q[AW'(reg_wdata[30:24])] <= reg_wdata[CW-1:0];
		end else if (reg_wr && reg_addr == txd_pkg::REG_COEF) begin
			cf_i[AW'(reg_wdata[30:24])] <= reg_wdata[CW-1:0];
		end
	end

	// Output link clock from a divider; LVDS may leave it parked
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			lk_cnt_ff <= 16'h0000;
			lk_clk_ff <= 1'b0;
		end else if (!ctl_ff[txd_pkg::CTL_LEN] || (lane[1] && !ctl_ff[txd_pkg::CTL_OCK])) begin
			lk_cnt_ff <= 16'h0000;
			lk_clk_ff <= 1'b0;
		end else if (lk_cnt_ff >= rate_ff[txd_pkg::RT_LINK +: 16] - 16'h0001) begin
			lk_cnt_ff <= 16'h0000;
			lk_clk_ff <= ~lk_clk_ff;
		end else begin
			lk_cnt_ff <= lk_cnt_ff + 16'h0001;
		end
	end
	assign link.clk_out = lk_clk_ff;

	// Clock, strobe and lanes cross into the system clock together
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sy1_ff <= 6'h00;
			sy2_ff <= 6'h00;
			ck_prev_ff <= 1'b0;
		end else begin
			sy1_ff <= {link.clk_in, link.strobe, link.data};
			sy2_ff <= sy1_ff;
			ck_prev_ff <= sy2_ff[5];
		end
	end

	// Deframer: serial symbols to parallel I/Q pairs
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pos_ff <= 5'h00;
			ph_q_ff <= 1'b0;
			sym_on_ff <= 1'b0;
			sh_ff <= '{default: 16'h0000};
			hold_i_ff <= 16'h0000;
			df_i_ff <= 16'sh0000;
			df_q_ff <= 16'sh0000;
			df_vld_ff <= 1'b0;
			sym_cnt_ff <= 16'h0000;
		end else if (clr) begin
			pos_ff <= 5'h00;
			ph_q_ff <= 1'b0;
			sym_on_ff <= 1'b0;
			df_vld_ff <= 1'b0;
		end else begin
			df_vld_ff <= 1'b0;
			if (rise) begin
				sh_ff <= sh_n;
				sym_on_ff <= (sy2_ff[4] | sym_on_ff) & ~last;
				pos_ff <= last ? 5'h00 : 5'((sy2_ff[4] ? 5'h00 : pos_ff) + 5'h01);
			end
			if (take && lane == txd_pkg::LM_CMOS4) begin
				df_i_ff <= {sh_n[0][7:0], sh_n[1][7:0]};
				df_q_ff <= {sh_n[2][7:0], sh_n[3][7:0]};
				df_vld_ff <= 1'b1;
			end else if (take && lane == txd_pkg::LM_LVDS2) begin
				df_i_ff <= 16'(sh_n[0] << (5'h10 - w));
				df_q_ff <= 16'(sh_n[1] << (5'h10 - w));
				df_vld_ff <= 1'b1;
			end else if (take && !ph_q_ff) begin
				hold_i_ff <= 16'(sh_n[0] << (5'h10 - w));
				ph_q_ff <= 1'b1;
			end else if (take) begin
				df_i_ff <= hold_i_ff;
				df_q_ff <= 16'(sh_n[0] << (5'h10 - w));
				ph_q_ff <= 1'b0;
				df_vld_ff <= 1'b1;
			end
			if (df_vld_ff) begin
				sym_cnt_ff <= sym_cnt_ff + 16'h0001;
			end
		end
	end

	// Overrun is sticky; a new drop wins over a clear written together
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ovr_ff <= 1'b0;
		end else if (df_vld_ff && fs_ff != F_IDLE) begin
			ovr_ff <= 1'b1;
		end else if (reg_wr && reg_addr == txd_pkg::REG_STAT && reg_wdata[0]) begin
			ovr_ff <= 1'b0;
		end
	end

	// Delay lines: zeroed by the clear sweep, then written per sample
	always_ff @(posedge clk_sys) begin
		if (fs_ff == F_CLR) begin
			dl_i[k_ff] <= 16'sh0000;
			dl_q[k_ff] <= 16'sh0000;
		end else if (fs_ff == F_IDLE && df_vld_ff && fm >= txd_pkg::FIR_PAR
			&& fm <= txd_pkg::FIR_SEQ) begin
			dl_i[AW'(wp_ff + 1'b1)] <= df_i_ff;
			if (fm != txd_pkg::FIR_SEQ) begin
				dl_q[AW'(wp_ff + 1'b1)] <= df_q_ff;
			end
		end else if (fs_ff == F_OUT && fm == txd_pkg::FIR_SEQ && !pass_ff) begin
			dl_q[wp_ff] <= sat(acc_i_ff);
		end
	end

	// One tap per cycle per filter; a sample takes TAPS+1 cycles, 2*TAPS+2 in series mode
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			fs_ff <= F_CLR;
			k_ff <= '0;
			wp_ff <= '0;
			pass_ff <= 1'b0;
			acc_i_ff <= '0;
			acc_q_ff <= '0;
			in_i_ff <= 16'sh0000;
			in_q_ff <= 16'sh0000;
			fir_i_ff <= 16'sh0000;
			fir_q_ff <= 16'sh0000;
		end else if (clr) begin
			fs_ff <= F_CLR;
			k_ff <= '0;
			fir_i_ff <= 16'sh0000;
			fir_q_ff <= 16'sh0000;
		end else begin
			unique case (fs_ff)
				F_CLR: begin
					k_ff <= AW'(k_ff + 1'b1);
					if (k_ff == AW'(TAPS - 1)) begin
						fs_ff <= F_IDLE;
					end
				end
				F_IDLE: begin
					if (df_vld_ff && (fm < txd_pkg::FIR_PAR || fm > txd_pkg::FIR_SEQ)) begin
						fir_i_ff <= df_i_ff;
						fir_q_ff <= df_q_ff;
					end else if (df_vld_ff) begin
						in_i_ff <= df_i_ff;
						in_q_ff <= df_q_ff;
						wp_ff <= AW'(wp_ff + 1'b1);
						k_ff <= '0;
						pass_ff <= 1'b0;
						acc_i_ff <= '0;
						acc_q_ff <= '0;
						fs_ff <= F_MAC;
					end
				end
				F_MAC: begin
					acc_i_ff <= acc_i_ff + AC'(dl_i[rp] * cf_i[k_ff]);
					acc_q_ff <= acc_q_ff + AC'(dl_q[rp] * cf_q[k_ff]);
					k_ff <= AW'(k_ff + 1'b1);
					if (k_ff == AW'(TAPS - 1)) begin
						fs_ff <= F_OUT;
					end
				end
				F_OUT: begin
					if (fm == txd_pkg::FIR_SEQ && !pass_ff) begin
						pass_ff <= 1'b1;
						acc_q_ff <= '0;
						fs_ff <= F_MAC;
					end else begin
						fir_i_ff <= (fm == txd_pkg::FIR_SEQ) ? sat(acc_q_ff)
							: (fm == txd_pkg::FIR_QON) ? in_i_ff : sat(acc_i_ff);
						fir_q_ff <= (fm == txd_pkg::FIR_PAR || fm == txd_pkg::FIR_QON)
							? sat(acc_q_ff) : in_q_ff;
						fs_ff <= F_IDLE;
					end
				end
			endcase
		end
	end

	// Rate ticks: stage 2 steps every DAC tick, stage 1 on stage-2 wrap
	always_comb begin
		tick = (dac_cnt_ff == rate_ff[7:0]);
		wrap2 = tick & (k2_ff == 3'(({1'b0, 2'h1} << ctl_ff[txd_pkg::CTL_L2 +: 2]) - 3'h1));
		wrap1 = wrap2 & (k1_ff == 3'(({1'b0, 2'h1} << ctl_ff[txd_pkg::CTL_L1 +: 2]) - 3'h1));
		s1_i = lin(o1_i_ff, n1_i_ff, k1_ff, ctl_ff[txd_pkg::CTL_L1 +: 2]);
		s1_q = lin(o1_q_ff, n1_q_ff, k1_ff, ctl_ff[txd_pkg::CTL_L1 +: 2]);
		p_i = s1_i;
		p_q = s1_q;
		if (ctl_ff[txd_pkg::CTL_MOD]) begin
			p_i = sin8(3'(nco_ff[15:13] + 3'h2));
			p_q = sin8(nco_ff[15:13]);
		end
		if (ctl_ff[txd_pkg::CTL_UPC]) begin
			unique case (rot_ff)
				2'h0: {p_i, p_q} = {p_i, p_q};
				2'h1: {p_i, p_q} = {16'(-p_q), p_i};
				2'h2: {p_i, p_q} = {16'(-p_i), 16'(-p_q)};
				2'h3: {p_i, p_q} = {p_q, 16'(-p_i)};
			endcase
		end
	end

	// Interpolator pipeline, modulator state and outputs
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			dac_cnt_ff <= 8'h00;
			{k1_ff, k2_ff, rot_ff, nco_ff} <= '0;
			{o1_i_ff, o1_q_ff, n1_i_ff, n1_q_ff} <= '0;
			{o2_i_ff, o2_q_ff, n2_i_ff, n2_q_ff} <= '0;
			{dac_i, dac_q, dac_valid, sdm_word, sdm_valid} <= '0;
		end else if (clr) begin
			{k1_ff, k2_ff, rot_ff, nco_ff} <= '0;
			{o1_i_ff, o1_q_ff, n1_i_ff, n1_q_ff} <= '0;
			{o2_i_ff, o2_q_ff, n2_i_ff, n2_q_ff} <= '0;
			{dac_i, dac_q, dac_valid, sdm_valid} <= '0;
		end else begin
			dac_cnt_ff <= tick ? 8'h00 : dac_cnt_ff + 8'h01;
			dac_valid <= tick & ~dfm;
			sdm_valid <= wrap2 & dfm;
			if (tick) begin
				k2_ff <= wrap2 ? 3'h0 : k2_ff + 3'h1;
				dac_i <= dfm ? 16'h0000 : lin(o2_i_ff, n2_i_ff, k2_ff, ctl_ff[txd_pkg::CTL_L2 +: 2]);
				dac_q <= dfm ? 16'h0000 : lin(o2_q_ff, n2_q_ff, k2_ff, ctl_ff[txd_pkg::CTL_L2 +: 2]);
			end
			if (wrap2) begin
				k1_ff <= wrap1 ? 3'h0 : k1_ff + 3'h1;
				{o2_i_ff, o2_q_ff} <= {n2_i_ff, n2_q_ff};
				{n2_i_ff, n2_q_ff} <= dfm ? 32'h0000_0000 : {p_i, p_q};
				nco_ff <= (ctl_ff[txd_pkg::CTL_MOD] && !dfm) ? nco_ff + s1_i : nco_ff;
				rot_ff <= (ctl_ff[txd_pkg::CTL_UPC] && !dfm) ? rot_ff + 2'h1 : rot_ff;
				if (dfm) begin
					sdm_word <= s1_i;
				end
			end
			if (wrap1) begin
				{o1_i_ff, o1_q_ff} <= {n1_i_ff, n1_q_ff};
				{n1_i_ff, n1_q_ff} <= {fir_i_ff, fir_q_ff};
			end
		end
	end

	assign dac_pd = dfm;
	assign lpf_pd = dfm;
endmodule

// File: testbench/txd_link_assertions.sv
// Checker on the serial link between baseband and front end.
// Assumes default RATE (half period 4 clk) and a fresh reset per mode.
module txd_link_assertions (
	input wire logic       clk_sys, // System clock
	input wire logic       rstn,    // Async reset, active low
	input wire logic       clk_out, // Device link clock
	input wire logic       clk_in,  // Returned link clock
	input wire logic       strobe,  // Symbol start
	input wire logic [3:0] data     // Data lanes
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);
	// Each clock phase lasts exactly four system cycles
	sequence s_hi;
		clk_out [*4] ##1 !clk_out;
	endsequence
	sequence s_lo;
		!clk_out [*4] ##1 clk_out;
	endsequence
	AST_CLK_HIGH: assert property ($rose(clk_out) |-> s_hi)
		else $error("link clock high phase wrong");
	AST_CLK_LOW: assert property ($fell(clk_out) |-> s_lo)
		else $error("link clock low phase wrong");
	AST_RET_RISE: assert property ($rose(clk_out) |-> ##[1:4] $rose(clk_in))
		else $error("returned clock late on rise");
	AST_RET_FALL: assert property ($fell(clk_out) |-> ##[1:4] $fell(clk_in))
		else $error("returned clock late on fall");
	// Launch on the falling side keeps data away from the sampling rise
	AST_DATA_LOW: assert property (!$stable(data) |-> !clk_out)
		else $error("data moved while clock high");
	AST_STB_LOW: assert property (!$stable(strobe) |-> !clk_out)
		else $error("strobe moved while clock high");
	AST_STB_BIT: assert property ($rose(strobe) |-> strobe [*6] ##[1:4] !strobe)
		else $error("strobe not one bit long");
	AST_RST_QUIET: assert property ($rose(rstn) |-> !clk_out && !strobe && data == 4'h0)
		else $error("link not quiet after reset");
endmodule

// File: testbench/tb_top.sv
// Bench: both link ends joined; registers and samples driven, outputs checked.
// Assumes default RATE; the DAC, or sdm_word in DFM mode, holds the last sample, halved when filters run.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys = 0, rstn = 0, reg_wr = 0, reg_rd = 0, rd_d = 0; // Clock, strobes
	logic [7:0]  reg_addr = 0;                // Register address
	logic [31:0] reg_wdata = 0, reg_rdata;    // Register data
	logic [15:0] dac_i, dac_q, sdm_word, li, lq; // Outputs, last pair sent
	logic        dac_valid, sdm_valid, dac_pd, lpf_pd, tx_ready, busy;
	logic [1:0]  lane = 0, code = 0;          // Baseband config
	logic [15:0] tx_i = 0, tx_q = 0;          // Offered pair
	logic        tx_valid = 0;                // Pair offered
	logic [31:0] exp_q[$];                    // Expected read data, oldest first
	int          errors = 0, num_checks = 0, cyc = 0, n;
	txd_link_if link_if();
	txd_device txd_device_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link_if),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .dac_i(dac_i), .dac_q(dac_q), .dac_valid(dac_valid),
		.sdm_word(sdm_word), .sdm_valid(sdm_valid), .dac_pd(dac_pd), .lpf_pd(lpf_pd));
	txd_baseband txd_baseband_inst (.clk_sys(clk_sys), .rstn(rstn), .link(link_if),
		.lane_mode(lane), .width_code(code), .tx_i(tx_i), .tx_q(tx_q),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy));
	txd_link_assertions txd_link_assertions_inst (.clk_sys(clk_sys), .rstn(rstn),
		.clk_out(link_if.clk_out), .clk_in(link_if.clk_in),
		.strobe(link_if.strobe), .data(link_if.data));
	initial forever #2 clk_sys = ~clk_sys;
	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Read data stands from the cycle after the strobe until the next read
	always @(posedge clk_sys) begin
		if (rd_d)
			ck(reg_rdata, exp_q.pop_front());
		rd_d <= reg_rd;
	end
	// One bus cycle, then one idle so strobes never change twice per step
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		if (!w)
			exp_q.push_back(d);
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clk_sys);
	endtask
	// Fresh reset, mode set, four random pairs sent, results checked
	task automatic run(input logic [1:0] lm, wc, input logic [15:0] m, input logic dfm,
		input logic [2:0] fir = txd_pkg::FIR_OFF);
		logic [31:0] c;
		c = {16'h0, lm[1], 1'b1, 4'h0, dfm, 2'h0, fir, wc, lm};
		rstn <= 1'b0;
		lane <= lm;
		code <= wc;
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		bus(1'b1, txd_pkg::REG_CTRL, {1'b1, c[30:0]});
		bus(1'b0, txd_pkg::REG_CTRL, c);
		bus(1'b0, 8'h10, 32'h0);
		// Tap 0 of both filters at one half, every other tap zero
		for (int t = 0; t < 256 && fir != txd_pkg::FIR_OFF; t++)
			bus(1'b1, txd_pkg::REG_COEF,
				{t[7:0], ((t[6:0] == 7'h00) ? 24'h40_0000 : 24'h00_0000)});
		repeat (140) @(posedge clk_sys); // Clear sweep drops pairs
		n = 0;
		tx_valid <= 1'b1;
		while (n < 4) begin
			@(posedge clk_sys);
			if (tx_ready === 1'b1) begin
				n++;
				li = tx_i & m;
				lq = tx_q & m;
				tx_i <= 16'($urandom);
				tx_q <= 16'($urandom);
			end
		end
		tx_valid <= 1'b0;
		if (fir != txd_pkg::FIR_OFF) begin
			li = 16'($signed(li) >>> 1);
			lq = 16'($signed(lq) >>> 1);
		end
		for (int k = 0; k < 3000 && busy !== 1'b0; k++)
			@(posedge clk_sys);
		repeat (300) @(posedge clk_sys);
		bus(1'b0, txd_pkg::REG_STAT, 32'h0004_0000);
		ck(32'({dac_pd, lpf_pd, dfm ? sdm_word : dac_i}), 32'({dfm, dfm, li}));
		ck(32'(dac_q), dfm ? 32'h0 : 32'(lq));
		ck(32'({dac_valid, sdm_valid}), 32'({!dfm, dfm}));
	endtask
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// Hang guard well above the expected 6600 or so cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		void'($urandom(93));
		repeat (10) @(posedge clk_sys);
		run(txd_pkg::LM_CMOS1, txd_pkg::WC_2, 16'hC000, 1'b0);
		run(txd_pkg::LM_CMOS1, txd_pkg::WC_8, 16'hFF00, 1'b0);
		run(txd_pkg::LM_CMOS4, txd_pkg::WC_8, 16'hFFFF, 1'b0);
		run(txd_pkg::LM_LVDS2, txd_pkg::WC_12, 16'hFFF0, 1'b0);
		run(txd_pkg::LM_LVDS1, txd_pkg::WC_16, 16'hFFFF, 1'b0, txd_pkg::FIR_PAR);
		run(txd_pkg::LM_CMOS1, txd_pkg::WC_16, 16'hFFFF, 1'b1);
		final_report();
	end
endmodule
